/* File: verilog/can_tx_select_abort_ack_filter_ctrl.sv */
// Operation
// - Abort-ack register held reset in init mode
// - Set abort-ack when buffer aborted by request
// - Clearing empty flag clears its abort-ack
// - Select read returns lowest set bit only
// - Lowest set select bit maps into window
// - Block window while selected buffer scheduled
// - Select writable outside init, else held reset
// - No buffer selected means no window access
// - Mode field picks filter organization
// - Closed mode accepts no message
// - Hit field reports matching filter index
// - Hit updates when foreground buffer reloads
// - Control writes only in init; hit read-only
// - Test register reads zero, ignores writes
// - Abort sets empty flag, ack, interrupt
// - Sent sets empty; software clear schedules
`timescale 1ns/1ps
`default_nettype none

module can_tx_select_abort_ack_filter_ctrl (
    // AHB-Lite clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Frame engine events
    input wire can_txsel_pkg::engine_event_t engine_event,
    // Frame engine view
    output can_txsel_pkg::tx_window_t tx_window,
    output logic [2:0] tx_scheduled,
    output logic [2:0] abort_request_bits,
    output logic [1:0] acceptance_mode_field,
    output logic rx_foreground_load,
    // Interrupt
    output logic irq
);

    // ----------------------------------------
    // Address phase capture
    // ----------------------------------------
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
        end else if (hready) begin
            dp_valid <= hsel && (htrans == can_txsel_pkg::htrans_nonseq || htrans == can_txsel_pkg::htrans_seq);
            dp_write <= hwrite;
            dp_addr <= haddr;
        end
    end

    logic wr_en;
    logic rd_en;
    assign wr_en = dp_valid && dp_write;
    assign rd_en = dp_valid && !dp_write;

    // ----------------------------------------
    // Register decode for the data phase
    // ----------------------------------------
    logic wr_mode_ctrl;
    logic wr_tx_empty;
    logic wr_abort_req;
    logic wr_tx_select;
    logic wr_accept_ctrl;
    logic wr_irq_mask;
    logic rd_irq_status;

    // Writes land at the end of the data phase, when hwdata stands
    assign wr_mode_ctrl = wr_en && dp_addr == can_txsel_pkg::addr_mode_ctrl;
    assign wr_tx_empty = wr_en && dp_addr == can_txsel_pkg::addr_tx_empty;
    assign wr_abort_req = wr_en && dp_addr == can_txsel_pkg::addr_abort_req;
    assign wr_tx_select = wr_en && dp_addr == can_txsel_pkg::addr_tx_select;
    assign wr_accept_ctrl = wr_en && dp_addr == can_txsel_pkg::addr_accept_ctrl;
    assign wr_irq_mask = wr_en && dp_addr == can_txsel_pkg::addr_irq_mask;
    assign rd_irq_status = rd_en && dp_addr == can_txsel_pkg::addr_irq_status;

    // ----------------------------------------
    // Mode control
    // ----------------------------------------
    logic init_request;
    logic init_acknowledge;
    logic init_mode;
    assign init_mode = init_request && init_acknowledge;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            init_request <= 1'b0;
        end else if (wr_mode_ctrl) begin
            init_request <= hwdata[can_txsel_pkg::init_rq_bit];
        end
    end

    // Acknowledge follows the request one cycle later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            init_acknowledge <= 1'b0;
        end else begin
            init_acknowledge <= init_request;
        end
    end

    // ----------------------------------------
    // Transmit empty flags and abort requests
    // ----------------------------------------
    logic [2:0] tx_buffer_empty_flag;
    logic [2:0] empty_clear;
    logic [2:0] empty_set;
    logic [2:0] abort_set;
    logic [2:0] next_tx_buffer_empty_flag;
    logic [2:0] next_tx_scheduled;

    assign empty_clear = (wr_tx_empty && !init_mode) ? hwdata[2:0] : 3'h0;
    assign empty_set = engine_event.sent | engine_event.aborted;
    // Only a buffer that is still queued can take an abort request
    assign abort_set = (wr_abort_req && !init_mode) ? (hwdata[2:0] & ~tx_buffer_empty_flag) : 3'h0;

    // A sent or aborted buffer wins over a clear in the same cycle
    assign next_tx_buffer_empty_flag = (tx_buffer_empty_flag & ~empty_clear) | empty_set;

    // Engine and window both see the flags as they stand after this edge
    assign next_tx_scheduled = init_mode ? 3'h0 : ~next_tx_buffer_empty_flag;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_buffer_empty_flag <= can_txsel_pkg::empty_reset;
        end else if (init_mode) begin
            tx_buffer_empty_flag <= can_txsel_pkg::empty_reset;
        end else begin
            tx_buffer_empty_flag <= next_tx_buffer_empty_flag;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            abort_request_bits <= '0;
        end else if (init_mode) begin
            abort_request_bits <= '0;
        end else begin
            // A buffer flagged empty drops its pending request
            abort_request_bits <= (abort_request_bits | abort_set) & ~empty_set;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_scheduled <= '0;
        end else begin
            tx_scheduled <= next_tx_scheduled;
        end
    end

    // ----------------------------------------
    // Abort acknowledge
    // ----------------------------------------
    logic [2:0] abort_ack_bits;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            abort_ack_bits <= can_txsel_pkg::abort_ack_reset;
        end else if (init_mode) begin
            abort_ack_bits <= can_txsel_pkg::abort_ack_reset;
        end else begin
            // Abort in the same cycle as a clear wins
            abort_ack_bits <= (abort_ack_bits & ~empty_clear) | engine_event.aborted;
        end
    end

    // ----------------------------------------
    // Transmit buffer select
    // ----------------------------------------
    logic [2:0] tx_buffer_select;
    logic [2:0] select_lowest;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_buffer_select <= can_txsel_pkg::select_reset;
        end else if (init_mode) begin
            tx_buffer_select <= can_txsel_pkg::select_reset;
        end else if (wr_tx_select) begin
            tx_buffer_select <= hwdata[2:0];
        end
    end

    assign select_lowest = tx_buffer_select & (~tx_buffer_select + 3'h1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_window <= '0;
        end else begin
            tx_window.selected <= select_lowest;
            // Zero selection or a scheduled selected buffer closes the window
            tx_window.access_ok <= (select_lowest != 3'h0) && ((select_lowest & next_tx_scheduled) == 3'h0);
        end
    end

    // ----------------------------------------
    // Acceptance control
    // ----------------------------------------
    logic [2:0] filter_hit_index;
    logic rx_accept;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acceptance_mode_field <= can_txsel_pkg::mode_reset;
        end else if (wr_accept_ctrl && init_mode) begin
            acceptance_mode_field <= hwdata[can_txsel_pkg::mode_msb:can_txsel_pkg::mode_lsb];
        end
    end

    assign rx_accept = engine_event.rx_shift && engine_event.rx_match &&
                       acceptance_mode_field != can_txsel_pkg::accept_closed;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_foreground_load <= 1'b0;
        end else begin
            rx_foreground_load <= rx_accept;
        end
    end

    // Hit index follows the message now in the foreground buffer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            filter_hit_index <= can_txsel_pkg::hit_reset;
        end else if (rx_accept) begin
            filter_hit_index <= engine_event.rx_hit;
        end
    end

    // ----------------------------------------
    // Interrupt status and mask
    // ----------------------------------------
    logic [6:0] irq_status;
    logic [6:0] irq_mask;
    logic [6:0] irq_event;
    logic [6:0] next_irq_status;

    assign irq_event = {rx_accept, engine_event.aborted, empty_set};

    // Clear on read; an event in the clearing cycle stays set
    always_comb begin
        next_irq_status = irq_status | irq_event;
        if (rd_irq_status) begin
            next_irq_status = irq_event;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= 7'h00;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask <= 7'h00;
        end else if (wr_irq_mask) begin
            irq_mask <= hwdata[6:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_irq_status & irq_mask);
        end
    end

    // ----------------------------------------
    // Read data, registered in the address phase
    // ----------------------------------------
    logic [31:0] next_hrdata;

    always_comb begin
        next_hrdata = 32'h0000_0000;
        case (haddr)
            can_txsel_pkg::addr_abort_ack: next_hrdata = {29'h0, abort_ack_bits};
            can_txsel_pkg::addr_tx_select: next_hrdata = {29'h0, select_lowest};
            can_txsel_pkg::addr_accept_ctrl: next_hrdata = {26'h0, acceptance_mode_field, 1'b0, filter_hit_index};
            can_txsel_pkg::addr_test_rsvd: next_hrdata = 32'h0000_0000;
            can_txsel_pkg::addr_tx_empty: next_hrdata = {29'h0, tx_buffer_empty_flag};
            can_txsel_pkg::addr_abort_req: next_hrdata = {29'h0, abort_request_bits};
            can_txsel_pkg::addr_mode_ctrl: next_hrdata = {30'h0, init_acknowledge, init_request};
            // Shows this cycle's events too, so none is lost by the clear
            can_txsel_pkg::addr_irq_status: next_hrdata = {25'h0, irq_status | irq_event};
            can_txsel_pkg::addr_irq_mask: next_hrdata = {25'h0, irq_mask};
            can_txsel_pkg::addr_hit_status: next_hrdata = {29'h0, filter_hit_index};
            default: next_hrdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready) begin
            hrdata <= next_hrdata;
        end
    end

    // Zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    // Every transfer answers OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* File: verilog/can_txsel_pkg.sv */
package can_txsel_pkg;

    // ----------------------------------------
    // Register byte addresses
    // ----------------------------------------
    localparam logic [7:0] addr_abort_ack = 8'h00;
    localparam logic [7:0] addr_tx_select = 8'h04;
    localparam logic [7:0] addr_accept_ctrl = 8'h08;
    localparam logic [7:0] addr_test_rsvd = 8'h0C;
    localparam logic [7:0] addr_tx_empty = 8'h10;
    localparam logic [7:0] addr_abort_req = 8'h14;
    localparam logic [7:0] addr_mode_ctrl = 8'h18;
    localparam logic [7:0] addr_irq_status = 8'h1C;
    localparam logic [7:0] addr_irq_mask = 8'h20;
    localparam logic [7:0] addr_hit_status = 8'h24;

    // ----------------------------------------
    // Field layout and reset values
    // ----------------------------------------
    localparam int num_tx_buf = 3;
    localparam int mode_lsb = 4;
    localparam int mode_msb = 5;
    localparam int hit_msb = 2;
    localparam int init_rq_bit = 0;
    localparam int init_ak_bit = 1;
    localparam logic [2:0] abort_ack_reset = 3'h0;
    localparam logic [2:0] select_reset = 3'h0;
    localparam logic [2:0] empty_reset = 3'h7;
    localparam logic [1:0] mode_reset = 2'h0;
    localparam logic [2:0] hit_reset = 3'h0;

    // ----------------------------------------
    // Interrupt status bit positions
    // ----------------------------------------
    localparam int irq_tx_empty_lsb = 0;
    localparam int irq_abort_lsb = 3;
    localparam int irq_rx_bit = 6;
    localparam int irq_width = 7;

    typedef enum logic [1:0] {
        accept_two_32 = 2'h0,
        accept_four_16 = 2'h1,
        accept_eight_8 = 2'h2,
        accept_closed = 2'h3
    } accept_mode_t;

    typedef enum logic [1:0] {
        htrans_idle = 2'h0,
        htrans_busy = 2'h1,
        htrans_nonseq = 2'h2,
        htrans_seq = 2'h3
    } htrans_t;

    // Events from the frame engine
    typedef struct packed {
        logic [2:0] sent;
        logic [2:0] aborted;
        logic rx_shift;
        logic rx_match;
        logic [2:0] rx_hit;
    } engine_event_t;

    // Transmit window view for the frame buffers
    typedef struct packed {
        logic [2:0] selected;
        logic access_ok;
    } tx_window_t;

endpackage

/* File: verif/can_txsel_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module can_txsel_checker (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Watched ports
    input wire can_txsel_pkg::engine_event_t engine_event,
    input wire can_txsel_pkg::tx_window_t tx_window,
    input wire logic [2:0] tx_scheduled,
    input wire logic [1:0] acceptance_mode_field,
    input wire logic rx_foreground_load
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ----
    // Properties
    // ----
    abort_frees_buf_a: assert property (engine_event.aborted[0] && tx_scheduled[0] |-> ##[1:2] !tx_scheduled[0])
        else $error("aborted buffer stays scheduled");
    sent_frees_buf_a: assert property (engine_event.sent[1] && tx_scheduled[1] |-> ##[1:2] !tx_scheduled[1])
        else $error("sent buffer stays scheduled");
    single_select_a: assert property ($onehot0(tx_window.selected))
        else $error("more than one buffer in window");
    none_no_access_a: assert property (tx_window.selected == 3'h0 |-> !tx_window.access_ok)
        else $error("window open with no buffer");
    busy_blocks_a: assert property (tx_window.access_ok |-> (tx_window.selected & tx_scheduled) == 3'h0)
        else $error("window open on scheduled buffer");
    closed_no_load_a: assert property (acceptance_mode_field == 2'h3 && engine_event.rx_shift |=> !rx_foreground_load)
        else $error("load in closed mode");
    accept_loads_a: assert property (engine_event.rx_shift && engine_event.rx_match && acceptance_mode_field != 2'h3
        |=> rx_foreground_load)
        else $error("accepted message not loaded");
    load_cause_a: assert property (rx_foreground_load |-> $past(engine_event.rx_shift) && $past(engine_event.rx_match))
        else $error("load without accepted shift");
endmodule
bind can_tx_select_abort_ack_filter_ctrl can_txsel_checker can_txsel_checker_i (.hclk(hclk), .hresetn(hresetn),
    .engine_event(engine_event), .tx_window(tx_window), .tx_scheduled(tx_scheduled),
    .acceptance_mode_field(acceptance_mode_field), .rx_foreground_load(rx_foreground_load));
`default_nettype wire

/* File: verif/can_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none
module can_engine_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bench commands
    input wire logic [2:0] do_send,
    input wire logic [2:0] do_abort,
    input wire logic do_rx,
    input wire logic [2:0] rx_hit,
    // Controller view
    input wire logic [2:0] tx_scheduled,
    input wire logic [2:0] abort_request_bits,
    output var can_txsel_pkg::engine_event_t engine_event
);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            engine_event <= '0;
        end else begin
            engine_event.sent <= do_send & tx_scheduled;
            engine_event.aborted <= do_abort & abort_request_bits & tx_scheduled;
            engine_event.rx_shift <= do_rx;
            engine_event.rx_match <= do_rx;
            engine_event.rx_hit <= rx_hit;
        end
    end
endmodule
`default_nettype wire

/* File: verif/can_tx_select_abort_ack_filter_ctrl_test.sv */
`timescale 1ns/1ps
`default_nettype none
module can_tx_select_abort_ack_filter_ctrl_test;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, irq, rx_foreground_load, do_rx = 1'b0;
    logic [2:0] tx_scheduled, abort_request_bits, do_send = 3'h0, do_abort = 3'h0, rx_hit = 3'h0;
    logic [1:0] acceptance_mode_field;
    can_txsel_pkg::engine_event_t engine_event;
    can_txsel_pkg::tx_window_t tx_window;
    int errors = 0;
    int n_checks = 0;
    can_tx_select_abort_ack_filter_ctrl can_tx_select_abort_ack_filter_ctrl_i (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .engine_event(engine_event),
        .tx_window(tx_window), .tx_scheduled(tx_scheduled), .abort_request_bits(abort_request_bits),
        .acceptance_mode_field(acceptance_mode_field), .rx_foreground_load(rx_foreground_load), .irq(irq));
    can_engine_model can_engine_model_i (.hclk(hclk), .hresetn(hresetn), .do_send(do_send), .do_abort(do_abort),
        .do_rx(do_rx), .rx_hit(rx_hit), .tx_scheduled(tx_scheduled), .abort_request_bits(abort_request_bits),
        .engine_event(engine_event));
    initial begin
        forever #2 hclk = ~hclk;
    end
    // ----
    // Bus and check tasks
    // ----
    task automatic finish_test();
        if (errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (hreadyout !== 1'b1) begin
            @(posedge hclk);
            n++;
            if (n > 50) begin
                errors++;
                $display("ERROR %0t bus hang", $time);
                finish_test();
            end
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge hclk);
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        wait_ready();
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask
    task automatic ev(input logic [2:0] s, input logic [2:0] ab, input logic rx, input logic [2:0] h);
        @(posedge hclk);
        do_send <= s;
        do_abort <= ab;
        do_rx <= rx;
        rx_hit <= h;
        @(posedge hclk);
        do_send <= 3'h0;
        do_abort <= 3'h0;
        do_rx <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_reset();
        rd(can_txsel_pkg::addr_abort_ack, 32'h0);
        rd(can_txsel_pkg::addr_tx_select, 32'h0);
        rd(can_txsel_pkg::addr_accept_ctrl, 32'h0);
        rd(can_txsel_pkg::addr_tx_empty, 32'h7);
        rd(8'h3C, 32'h0);
    endtask
    task automatic t_select();
        for (int v = 0; v < 8; v++) begin
            wr(can_txsel_pkg::addr_tx_select, 32'(v));
            rd(can_txsel_pkg::addr_tx_select, 32'(v & (~v + 1)));
            chk(32'(tx_window.selected), 32'(v & (~v + 1)));
            chk({31'h0, tx_window.access_ok}, {31'h0, v != 0});
        end
        wr(can_txsel_pkg::addr_test_rsvd, 32'hFF);
        rd(can_txsel_pkg::addr_test_rsvd, 32'h0);
    endtask
    task automatic t_window();
        wr(can_txsel_pkg::addr_tx_select, 32'h2);
        wr(can_txsel_pkg::addr_tx_empty, 32'h2);
        repeat (2) @(posedge hclk);
        chk(32'(tx_scheduled), 32'h2);
        chk({31'h0, tx_window.access_ok}, 32'h0);
        ev(3'h2, 3'h0, 1'b0, 3'h0);
        rd(can_txsel_pkg::addr_tx_empty, 32'h7);
        chk({31'h0, tx_window.access_ok}, 32'h1);
    endtask
    task automatic t_abort();
        logic [31:0] r;
        wr(can_txsel_pkg::addr_tx_empty, 32'h1);
        wr(can_txsel_pkg::addr_abort_req, 32'h1);
        rd(can_txsel_pkg::addr_abort_req, 32'h1);
        wr(can_txsel_pkg::addr_irq_mask, 32'h8);
        ev(3'h0, 3'h1, 1'b0, 3'h0);
        rd(can_txsel_pkg::addr_abort_ack, 32'h1);
        rd(can_txsel_pkg::addr_tx_empty, 32'h7);
        rd(can_txsel_pkg::addr_abort_req, 32'h0);
        chk({31'h0, irq}, 32'h1);
        bus(1'b0, can_txsel_pkg::addr_irq_status, 32'h0, r);
        chk(r, 32'hB);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        wr(can_txsel_pkg::addr_tx_empty, 32'h1);
        rd(can_txsel_pkg::addr_abort_ack, 32'h0);
        wr(can_txsel_pkg::addr_irq_mask, 32'h0);
        wr(can_txsel_pkg::addr_abort_req, 32'h1);
        ev(3'h0, 3'h1, 1'b0, 3'h0);
        rd(can_txsel_pkg::addr_abort_ack, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(can_txsel_pkg::addr_mode_ctrl, 32'h1);
        rd(can_txsel_pkg::addr_mode_ctrl, 32'h3);
        rd(can_txsel_pkg::addr_abort_ack, 32'h0);
        wr(can_txsel_pkg::addr_tx_select, 32'h1);
        rd(can_txsel_pkg::addr_tx_select, 32'h0);
    endtask
    task automatic t_filter();
        logic [2:0] hit;
        hit = 3'h0;
        for (int m = 0; m < 4; m++) begin
            wr(can_txsel_pkg::addr_mode_ctrl, 32'h1);
            wr(can_txsel_pkg::addr_accept_ctrl, 32'(m << 4) | 32'h7);
            wr(can_txsel_pkg::addr_mode_ctrl, 32'h0);
            wr(can_txsel_pkg::addr_accept_ctrl, 32'h30);
            ev(3'h0, 3'h0, 1'b1, 3'(m + 5));
            if (m != 3) begin
                hit = 3'(m + 5);
            end
            rd(can_txsel_pkg::addr_accept_ctrl, 32'(m << 4) | 32'(hit));
            chk(32'(acceptance_mode_field), 32'(m));
        end
    endtask
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_select();
        t_window();
        t_abort();
        t_filter();
        finish_test();
    end
endmodule
`default_nettype wire
